// ---- logic/rstseq_cnt_if.sv ----
// Purpose: Carrier between sequencer and its counter
// Assumes: Single clock
// Notes: Load restarts, done is a level
interface rstseq_cnt_if;
  logic load;
  logic [12:0] value;
  logic done;
  modport ctl (output load, output value, input done);
  modport cnt (input load, input value, output done);
endinterface

// ---- logic/rstseq_counter.sv ----
// Purpose: Down counter for phase lengths
// Assumes: Load has priority over counting
// Notes: Done is high while the count is zero
module rstseq_counter
  import rstseq_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Control
  rstseq_cnt_if.cnt cnt
);
  logic [12:0] cnt_q;
  logic [12:0] cnt_d;

  always_comb
  begin
    cnt_d = cnt_q;
    if (cnt.load)
    begin
      cnt_d = cnt.value;
    end
    else if (cnt_q != 13'h0000)
    begin
      cnt_d = cnt_q - 13'h0001;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      cnt_q <= 13'h0000;
    end
    else
    begin
      cnt_q <= cnt_d;
    end
  end

  // Done must not look at load: the sequencer forms load from done
  assign cnt.done = (cnt_q == 13'h0000);
endmodule // rstseq_counter

// ---- logic/rstseq_params.svh ----
// Purpose: Constants for the reset sequencer
// Assumes: 200 MHz clock, one CPU clock cycle per clk_in cycle
// Notes: Definitions only
`ifndef RSTSEQ_PARAMS_SVH
`define RSTSEQ_PARAMS_SVH
`define RSTSEQ_DLY_SHORT 13'h0100
`define RSTSEQ_DLY_LONG 13'h1000
`define RSTSEQ_FETCH_CYC 2'h2
`define RSTSEQ_VEC_LO_ADDR 16'hFFFE
`define RSTSEQ_VEC_HI_ADDR 16'hFFFF
`define RSTSEQ_CLK_PERIOD_NS 5
`define RSTSEQ_EXT_PULSE_NS 20
`define RSTSEQ_WDG_PULSE_NS 40
`define RSTSEQ_EXT_PULSE_CYC ((`RSTSEQ_EXT_PULSE_NS + `RSTSEQ_CLK_PERIOD_NS - 1) / `RSTSEQ_CLK_PERIOD_NS)
`define RSTSEQ_WDG_PULSE_CYC ((`RSTSEQ_WDG_PULSE_NS + `RSTSEQ_CLK_PERIOD_NS - 1) / `RSTSEQ_CLK_PERIOD_NS)
`define RSTSEQ_CLKSEL_EXT 3'h0
`define RSTSEQ_CLKSEL_RC 3'h5
`endif

// ---- logic/rstseq_pkg.sv ----
// Purpose: Types for the reset sequencer
// Assumes: Nothing
// Notes: One-hot phase encoding
package rstseq_pkg;
  typedef enum logic [3:0] {
    RSTSEQ_ACTIVE = 4'h1,
    RSTSEQ_DELAY = 4'h2,
    RSTSEQ_FETCH = 4'h4,
    RSTSEQ_RUN = 4'h8
  } rstseq_phase_t;
endpackage

// ---- logic/rstseq_sequencer.sv ----
// Purpose: Reset sequence manager of an 8-bit controller
// Assumes: Reset pin level synchronous to clk_in; option bits static
// Notes: Open-drain pin shown as in/out/oe; pull-up lives outside
module rstseq_sequencer
  import rstseq_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Reset pin, open drain
  input wire logic rst_pin_in,
  output logic rst_pin_out,
  output logic rst_pin_oe_out,
  // Reset sources and options
  input wire logic wdg_underflow_in,
  input wire logic opt_long_delay_in,
  input wire logic [2:0] opt_clk_sel_in,
  // Vector memory
  output logic [15:0] mem_addr_out,
  output logic mem_rd_out,
  input wire logic [7:0] mem_data_in,
  // Processor side
  output logic [15:0] pc_out,
  output logic pc_load_out,
  output logic cpu_rst_out,
  // Clock control
  output logic [2:0] clk_sel_out,
  output logic osc_enable_out
);
`include "rstseq_params.svh"

  rstseq_cnt_if cif ();

  rstseq_counter u_cnt (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .cnt(cif)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer state
  rstseq_phase_t phase_q, phase_d;
  logic [1:0] fetch_q, fetch_d;
  logic [7:0] vec_hi_q, vec_hi_d;
  logic [15:0] pc_q, pc_d;
  logic pc_load_q, pc_load_d;
  logic cpu_rst_q, cpu_rst_d;
  logic drive_q, drive_d;
  logic [15:0] addr_q, addr_d;
  logic rd_q, rd_d;
  logic [2:0] clk_sel_q, clk_sel_d;
  logic ext_req;
  logic start;

  // Low pin only counts when we are not driving it ourselves
  assign ext_req = !rst_pin_in && !drive_q;
  assign start = ext_req || wdg_underflow_in;

  always_comb
  begin
    phase_d = phase_q;
    fetch_d = fetch_q;
    vec_hi_d = vec_hi_q;
    pc_d = pc_q;
    pc_load_d = 1'b0;
    cpu_rst_d = cpu_rst_q;
    drive_d = drive_q;
    addr_d = addr_q;
    rd_d = 1'b0;
    clk_sel_d = clk_sel_q;
    cif.load = 1'b0;
    cif.value = 13'h0000;
    if (start && phase_q != RSTSEQ_FETCH)
    begin
      // Any new source restarts from the active phase
      phase_d = RSTSEQ_ACTIVE;
      cpu_rst_d = 1'b1;
      drive_d = 1'b1;
      cif.load = 1'b1;
      cif.value = wdg_underflow_in ? 13'(`RSTSEQ_WDG_PULSE_CYC) : 13'(`RSTSEQ_EXT_PULSE_CYC);
    end
    else if (start)
    begin
      phase_d = RSTSEQ_ACTIVE;
      cpu_rst_d = 1'b1;
      drive_d = 1'b1;
      cif.load = 1'b1;
      cif.value = 13'(`RSTSEQ_WDG_PULSE_CYC);
    end
    else
    begin
      case (phase_q)
        RSTSEQ_ACTIVE:
        begin
          if (cif.done)
          begin
            phase_d = RSTSEQ_DELAY;
            cif.load = 1'b1;
            // Counter ends on zero, so load one less to get the exact length
            cif.value = opt_long_delay_in ? (`RSTSEQ_DLY_LONG - 13'h0001) : (`RSTSEQ_DLY_SHORT - 13'h0001);
            clk_sel_d = opt_clk_sel_in;
          end
        end
        RSTSEQ_DELAY:
        begin
          drive_d = 1'b1;
          if (cif.done)
          begin
            phase_d = RSTSEQ_FETCH;
            drive_d = 1'b0;
            fetch_d = 2'h0;
            addr_d = `RSTSEQ_VEC_HI_ADDR;
            rd_d = 1'b1;
          end
        end
        RSTSEQ_FETCH:
        begin
          fetch_d = fetch_q + 2'h1;
          if (fetch_q == 2'h0)
          begin
            vec_hi_d = mem_data_in;
            addr_d = `RSTSEQ_VEC_LO_ADDR;
            rd_d = 1'b1;
          end
          if (fetch_q + 2'h1 == `RSTSEQ_FETCH_CYC)
          begin
            phase_d = RSTSEQ_RUN;
            pc_d = {vec_hi_q, mem_data_in};
            pc_load_d = 1'b1;
            cpu_rst_d = 1'b0;
          end
        end
        RSTSEQ_RUN:
        begin
          drive_d = 1'b0;
        end
        default:
        begin
          phase_d = RSTSEQ_ACTIVE;
          cpu_rst_d = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      phase_q <= RSTSEQ_ACTIVE;
      fetch_q <= 2'h0;
      vec_hi_q <= 8'h00;
      pc_q <= 16'h0000;
      pc_load_q <= 1'b0;
      cpu_rst_q <= 1'b1;
      drive_q <= 1'b1;
      addr_q <= 16'h0000;
      rd_q <= 1'b0;
      clk_sel_q <= `RSTSEQ_CLKSEL_EXT;
    end
    else
    begin
      phase_q <= phase_d;
      fetch_q <= fetch_d;
      vec_hi_q <= vec_hi_d;
      pc_q <= pc_d;
      pc_load_q <= pc_load_d;
      cpu_rst_q <= cpu_rst_d;
      drive_q <= drive_d;
      addr_q <= addr_d;
      rd_q <= rd_d;
      clk_sel_q <= clk_sel_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, registered except the constant pin data and oscillator enable
  // Open drain: data is always low, only the enable moves
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe_out = drive_q;
  assign mem_addr_out = addr_q;
  assign mem_rd_out = rd_q;
  assign pc_out = pc_q;
  assign pc_load_out = pc_load_q;
  assign cpu_rst_out = cpu_rst_q;
  assign clk_sel_out = clk_sel_q;
  // Oscillator never stopped by reset; saves start-up time
  assign osc_enable_out = 1'b1;
  // Pin level is taken on clk_in edges; a stopped clock would need an async path

  ////////////////////////////////////////////////////////////////////////
  // Delay phase length, counted apart from the phase counter so the checks do not trust it
  logic [12:0] dly_cnt_q, dly_cnt_d;

  always_comb
  begin
    dly_cnt_d = 13'h0000;
    if (phase_q == RSTSEQ_DELAY)
    begin
      dly_cnt_d = dly_cnt_q + 13'h0001;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      dly_cnt_q <= 13'h0000;
    end
    else
    begin
      dly_cnt_q <= dly_cnt_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property delay_drives_p;
    @(posedge clk_in) disable iff (srst_in) phase_q == RSTSEQ_DELAY |-> drive_q;
  endproperty
  pin_low_delay_a: assert property (delay_drives_p) else $error("Pin not driven in delay");

  sequence enter_fetch_s;
    phase_q == RSTSEQ_DELAY ##1 phase_q == RSTSEQ_FETCH;
  endsequence
  sequence fetch_hi_s;
    phase_q == RSTSEQ_FETCH && fetch_q == 2'h0 && rd_q && addr_q == `RSTSEQ_VEC_HI_ADDR;
  endsequence
  sequence fetch_lo_s;
    phase_q == RSTSEQ_FETCH && fetch_q == 2'h1 && rd_q && addr_q == `RSTSEQ_VEC_LO_ADDR;
  endsequence
  fetch_two_cycles_a: assert property (@(posedge clk_in) disable iff (srst_in)
    enter_fetch_s ##0 !start [*2] |=> phase_q == RSTSEQ_RUN && pc_load_q) else $error("Fetch not two cycles");

  vector_order_a: assert property (@(posedge clk_in) disable iff (srst_in)
    enter_fetch_s ##0 !start |-> fetch_hi_s ##1 fetch_lo_s) else $error("Vector reads out of order");

  delay_length_a: assert property (@(posedge clk_in) disable iff (srst_in)
    phase_q == RSTSEQ_DELAY && cif.done && !start |->
      dly_cnt_q == (opt_long_delay_in ? `RSTSEQ_DLY_LONG : `RSTSEQ_DLY_SHORT) - 13'h0001)
    else $error("Delay length wrong");

  order_phases_a: assert property (@(posedge clk_in) disable iff (srst_in)
    $rose(phase_q == RSTSEQ_FETCH) |-> $past(phase_q) == RSTSEQ_DELAY) else $error("Fetch not after delay");

  restart_seq_a: assert property (@(posedge clk_in) disable iff (srst_in)
    start |=> phase_q == RSTSEQ_ACTIVE && cpu_rst_q) else $error("Source did not restart");

  vector_load_a: assert property (@(posedge clk_in) disable iff (srst_in)
    pc_load_q |-> $past(addr_q) == `RSTSEQ_VEC_LO_ADDR) else $error("Wrong vector address");

  release_sync_a: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(cpu_rst_q) |-> pc_load_q && phase_q == RSTSEQ_RUN) else $error("Release out of step");

  cpu_held_a: assert property (@(posedge clk_in) disable iff (srst_in)
    phase_q != RSTSEQ_RUN |-> cpu_rst_q) else $error("Processor left reset early");

  // The pin may only be let go on the step from delay into fetch
  pin_release_a: assert property (@(posedge clk_in) disable iff (srst_in)
    $fell(drive_q) |-> phase_q == RSTSEQ_FETCH && $past(phase_q) == RSTSEQ_DELAY)
    else $error("Pin let go outside fetch");

  wdg_pulse_a: assert property (@(posedge clk_in) disable iff (srst_in)
    wdg_underflow_in |=> rst_pin_oe_out [*8]) else $error("Watchdog pulse too short");

  clk_sel_a: assert property (@(posedge clk_in) disable iff (srst_in)
    phase_q == RSTSEQ_RUN |-> clk_sel_out == $past(clk_sel_out)) else $error("Clock source moved");
endmodule // rstseq_sequencer

// ---- tb/rstseq_partner.sv ----
// Purpose: Pin wire and vector memory beside the sequencer
// Assumes: Read data answers while the read pulse stands
// Notes: Vector bytes are arbitrary test values
module rstseq_partner
  import rstseq_pkg::*;
#(
  parameter logic [7:0] VEC_HI = 8'hA5,
  parameter logic [7:0] VEC_LO = 8'h3C
)
(
  // Clock
  input wire logic clk_in,
  // Reset pin drivers
  input wire logic ext_low_in,
  input wire logic rst_pin_out_in,
  input wire logic rst_pin_oe_in,
  output logic pin_level_out,
  // Vector memory
  input wire logic mem_rd_in,
  input wire logic [15:0] mem_addr_in,
  output logic [7:0] mem_data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] data_q = 8'h00;
  // Open drain with pull-up: anyone pulling low wins
  assign pin_level_out = (ext_low_in || (rst_pin_oe_in && !rst_pin_out_in)) ? 1'b0 : 1'b1;
  // Stale data flips so a late sample never matches by luck
  always @(posedge clk_in)
  begin
    data_q <= ~data_q;
  end
  // The sequencer takes the byte at the edge that ends its read pulse
  assign mem_data_out = (mem_rd_in && mem_addr_in == 16'hFFFF) ? VEC_HI :
    ((mem_rd_in && mem_addr_in == 16'hFFFE) ? VEC_LO : data_q);
endmodule // rstseq_partner

// ---- tb/test_reset_sequence_manager.sv ----
// Purpose: Self-checking bench of the reset sequencer
// Assumes: Fetch walk and pulse lengths as handed over
// Notes: Delay window allows the active phase on top
`include "rstseq_params.svh"
module test_reset_sequence_manager;
  timeunit 1ns;
  timeprecision 1ps;
  import rstseq_pkg::*;
  typedef struct {logic [1:0] kind; logic lng; logic [2:0] sel; int dly;} rstseq_row_t;
  logic clk_in = 0, srst_in = 1, wdg_underflow_in = 0, opt_long_delay_in = 0, ext_low = 1;
  logic [2:0] opt_clk_sel_in = 3'h0, clk_sel_out;
  logic rst_pin_in, rst_pin_out, rst_pin_oe_out, mem_rd_out, pc_load_out, cpu_rst_out, osc_enable_out;
  logic [15:0] mem_addr_out, pc_out;
  logic [7:0] mem_data_in;
  int fails = 0, checks = 0, n, d;
  logic lo;
  rstseq_row_t rows [6] = '{'{2'h1, 1'b0, 3'h0, `RSTSEQ_DLY_SHORT}, '{2'h2, 1'b1, 3'h1, `RSTSEQ_DLY_LONG},
    '{2'h1, 1'b0, 3'h2, `RSTSEQ_DLY_SHORT}, '{2'h2, 1'b0, 3'h3, `RSTSEQ_DLY_SHORT},
    '{2'h1, 1'b1, 3'h4, `RSTSEQ_DLY_LONG}, '{2'h2, 1'b0, 3'h5, `RSTSEQ_DLY_SHORT}};
  initial
  begin
    forever #2.5 clk_in = ~clk_in;
  end
  rstseq_sequencer rstseq_sequencer_i (.clk_in(clk_in), .srst_in(srst_in), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe_out(rst_pin_oe_out), .wdg_underflow_in(wdg_underflow_in),
    .opt_long_delay_in(opt_long_delay_in), .opt_clk_sel_in(opt_clk_sel_in), .mem_addr_out(mem_addr_out),
    .mem_rd_out(mem_rd_out), .mem_data_in(mem_data_in), .pc_out(pc_out), .pc_load_out(pc_load_out),
    .cpu_rst_out(cpu_rst_out), .clk_sel_out(clk_sel_out), .osc_enable_out(osc_enable_out));
  rstseq_partner rstseq_partner_i (.clk_in(clk_in), .ext_low_in(ext_low), .rst_pin_out_in(rst_pin_out),
    .rst_pin_oe_in(rst_pin_oe_out), .pin_level_out(rst_pin_in), .mem_rd_in(mem_rd_out),
    .mem_addr_in(mem_addr_out), .mem_data_out(mem_data_in));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic test_done();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Kind 1 is a one-cycle watchdog request, 2 an external pulse of the minimum length
  task automatic trig(input logic [1:0] kind);
    if (kind == 2'h1)
    begin
      wdg_underflow_in <= 1'b1;
      @(posedge clk_in);
      wdg_underflow_in <= 1'b0;
    end
    else if (kind == 2'h2)
    begin
      ext_low <= 1'b1;
      repeat (`RSTSEQ_EXT_PULSE_CYC) @(posedge clk_in);
      ext_low <= 1'b0;
    end
  endtask
  task automatic seq(input string name, input logic [1:0] kind, input logic lng, input logic [2:0] sel,
    input int dly);
    opt_long_delay_in <= lng;
    opt_clk_sel_in <= sel;
    @(posedge clk_in);
    trig(kind);
    d = dly;
    n = 0;
    lo = 1'b1;
    #1;
    while (rst_pin_oe_out === 1'b1 && n < 5000)
    begin
      if (rst_pin_in !== 1'b0 || cpu_rst_out !== 1'b1)
        lo = 1'b0;
      @(posedge clk_in);
      #1;
      n++;
    end
    chk("delay_len", d[15:0], (n >= d && n <= d + 12) ? d[15:0] : n[15:0]);
    chk("pin_low", 16'h1, {15'h0, lo});
    chk("pin_data", 16'h0, {15'h0, rst_pin_out});
    chk("hi_addr", 16'hFFFF, mem_addr_out);
    chk("rd_pulse", 16'h1, {15'h0, mem_rd_out});
    n = 0;
    while (pc_load_out !== 1'b1 && n < 10)
    begin
      @(posedge clk_in);
      #1;
      if (n == 0)
        chk("lo_addr", 16'hFFFE, mem_addr_out);
      n++;
    end
    chk("fetch_len", 16'h2, n[15:0]);
    chk("pc", 16'hA53C, pc_out);
    chk("cpu_rst", 16'h0, {15'h0, cpu_rst_out});
    chk("clk_sel", {13'h0, sel}, {13'h0, clk_sel_out});
    chk("osc_on", 16'h1, {15'h0, osc_enable_out});
    $display("test %s done", name);
    // Back onto a clock edge so the next stimulus is driven at one
    @(posedge clk_in);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20) @(posedge clk_in);
    #1;
    chk("rst_cpu", 16'h1, {15'h0, cpu_rst_out});
    chk("rst_oe", 16'h1, {15'h0, rst_pin_oe_out});
    @(posedge clk_in);
    srst_in <= 1'b0;
    ext_low <= 1'b0;
    seq("power_up", 2'h0, 1'b0, 3'h0, `RSTSEQ_DLY_SHORT);
    foreach (rows[i])
      seq("row", rows[i].kind, rows[i].lng, rows[i].sel, rows[i].dly);
    // Second request mid-delay must restart the whole count
    @(posedge clk_in);
    trig(2'h1);
    repeat (100) @(posedge clk_in);
    seq("restart", 2'h1, 1'b0, 3'h2, `RSTSEQ_DLY_SHORT);
    // Reset in the middle of a delay, then a clean long sequence
    trig(2'h1);
    repeat (50) @(posedge clk_in);
    srst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    chk("mid_cpu", 16'h1, {15'h0, cpu_rst_out});
    chk("mid_oe", 16'h1, {15'h0, rst_pin_oe_out});
    @(posedge clk_in);
    srst_in <= 1'b0;
    seq("reset_mid", 2'h0, 1'b1, 3'h4, `RSTSEQ_DLY_LONG);
    test_done();
  end
  initial
  begin
    repeat (40000) @(posedge clk_in);
    fails++;
    test_done();
  end
endmodule // test_reset_sequence_manager
